// *** testbench/lsf_host_model.sv ***
// Purpose: host side model, an APB master that reads and writes device registers
// Assumes: one transfer at a time, slave may insert wait states
// Notes: released address and data lines show the inverse of their last value
`timescale 1ns/10ps
`default_nettype none
module lsf_host_model
  import lsf_pkg::*;
(
  input wire logic pclk,
  output var logic psel,
  output var logic penable,
  output var logic pwrite,
  output var logic [LSF_AW-1:0] paddr,
  output var logic [LSF_DW-1:0] pwdata,
  input wire logic pready,
  input wire logic [LSF_DW-1:0] prdata,
  input wire logic pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
  end

  // ===========================================================
  // one transfer; entered just after a rising edge
  task automatic xfer(input logic w, input logic [LSF_AW-1:0] a, input logic [LSF_DW-1:0] d,
                      output logic [LSF_DW-1:0] q, output logic e);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      tb.miscompares++;
      tb.summarize();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
    // an idle edge keeps the release and the next setup apart
    @(posedge pclk);
  endtask
endmodule
`default_nettype wire

// *** testbench/tb.sv ***
// Purpose: self-checking bench for the out-of-limit status flag block
// Assumes: zero-wait APB slave, one-cycle valid pulses per result
// Notes: limits stay at their reset defaults throughout
`timescale 1ns/10ps
`default_nettype none
module tb
  import lsf_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, fault;
  logic [LSF_AW-1:0] paddr;
  logic [LSF_DW-1:0] pwdata, prdata;
  logic [7:0] res [LSF_NCH];
  logic [LSF_NCH-1:0] vld;
  int miscompares = 0;
  int comparisons = 0;
  localparam logic [9:0] ST1 = {LSF_IDX_STAT1, 2'b00};
  localparam logic [9:0] ST2 = {LSF_IDX_STAT2, 2'b00};

  lsf_host_model host_u (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr));

  lsf_limit_status_flags dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .int_temp_result(res[0]), .int_temp_valid(vld[0]),
    .ext_result(res[1]), .ext_valid(vld[1]), .analog_input_two(res[2]),
    .analog_two_valid(vld[2]), .analog_input_three(res[3]), .analog_three_valid(vld[3]),
    .analog_input_four(res[4]), .analog_four_valid(vld[4]), .vdd_result(res[5]),
    .vdd_valid(vld[5]), .sensor_fault(fault),
    .irq(irq));

  // ===========================================================
  // helpers
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic rd(input logic [9:0] a, input logic [31:0] exp, input string what);
    logic [31:0] q;
    logic e;
    host_u.xfer(1'b0, a, '0, q, e);
    chk(what, q, exp);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] q;
    logic e;
    host_u.xfer(1'b1, {idx, 2'b00}, {24'h0, d}, q, e);
  endtask

  task automatic pulse(input int ch, input logic [7:0] v);
    res[ch] <= v;
    vld[ch] <= 1'b1;
    @(posedge pclk);
    vld[ch] <= 1'b0;
    @(posedge pclk);
  endtask

  // irq is looked at mid-cycle so the last edge has settled
  task automatic chk_irq(input logic exp);
    @(negedge pclk);
    chk("irq", {31'h0, irq}, {31'h0, exp});
    @(posedge pclk);
  endtask

  task automatic summarize();
    if (miscompares == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ===========================================================
  // scenarios
  task automatic t_reset();
    logic [31:0] q;
    logic e;
    rd(ST1, 32'h0, "status1 reset");
    rd(ST2, 32'h0, "status2 reset");
    chk_irq(1'b0);
    chk("pready", {31'h0, pready}, 32'h1);
    host_u.xfer(1'b0, {8'h29, 2'b00}, '0, q, e);
    chk("unmapped error", {31'h0, e}, 32'h1);
    chk("unmapped data", q, 32'h0);
    host_u.xfer(1'b0, 10'h001, '0, q, e);
    chk("misaligned error", {31'h0, e}, 32'h1);
  endtask

  task automatic t_int();
    pulse(LSF_CH_INT, 8'h64);
    rd(ST1, 32'h00, "int at upper");
    pulse(LSF_CH_INT, 8'h65);
    chk_irq(1'b1);
    wr(LSF_IDX_MASK1, 8'h01);
    chk_irq(1'b0);
    wr(LSF_IDX_MASK1, 8'h00);
    rd(ST1, 32'h01, "int above upper");
    rd(ST1, 32'h01, "held while out");
    pulse(LSF_CH_INT, 8'hCA);
    rd(ST1, 32'h01, "last read of flag");
    rd(ST1, 32'h00, "cleared after fix");
    chk_irq(1'b0);
    pulse(LSF_CH_INT, 8'hC9);
    rd(ST1, 32'h02, "int at lower");
    pulse(LSF_CH_INT, 8'h00);
    rd(ST1, 32'h02, "int lower read");
    rd(ST1, 32'h00, "int lower cleared");
  endtask

  task automatic t_ext();
    wr(LSF_IDX_CFG1, 8'h02);
    pulse(LSF_CH_EXT, 8'h00);
    rd(ST1, 32'h0C, "ext both limits");
    // minus one equals the default upper limit, so only the lower flag stays
    pulse(LSF_CH_EXT, 8'hFF);
    rd(ST1, 32'h0C, "ext minus one read");
    rd(ST1, 32'h08, "ext at upper");
    wr(LSF_IDX_SWRST, 8'h01);
    rd(ST1, 32'h00, "soft reset status1");
    wr(LSF_IDX_CFG1, 8'h06);
    pulse(LSF_CH_EXT, 8'h00);
    rd(ST1, 32'h04, "analog one at lower");
    pulse(LSF_CH_EXT, 8'h80);
    rd(ST1, 32'h04, "analog one read");
    rd(ST1, 32'h00, "analog one cleared");
  endtask

  task automatic t_fault_ain();
    fault <= 1'b1;
    @(posedge pclk);
    rd(ST1, 32'h10, "sensor fault");
    fault <= 1'b0;
    for (int k = LSF_CH_ANALOG2; k <= LSF_CH_ANALOG4; k++) begin
      pulse(k, 8'hFF);
    end
    rd(ST1, 32'h10, "analog at upper");
    for (int k = LSF_CH_ANALOG2; k <= LSF_CH_ANALOG4; k++) begin
      pulse(k, 8'h00);
    end
    rd(ST1, 32'hE0, "analog at lower");
    wr(LSF_IDX_SWRST, 8'h01);
    rd(ST1, 32'h00, "soft reset held");
  endtask

  task automatic t_vdd();
    pulse(LSF_CH_VDD, 8'hC8);
    chk_irq(1'b1);
    wr(LSF_IDX_MASK2, 8'h10);
    chk_irq(1'b0);
    wr(LSF_IDX_MASK2, 8'h00);
    rd(ST2, 32'h10, "vdd above upper");
    pulse(LSF_CH_VDD, 8'h80);
    rd(ST2, 32'h10, "vdd read");
    rd(ST2, 32'h00, "vdd cleared");
    chk_irq(1'b0);
    pulse(LSF_CH_VDD, 8'h62);
    rd(ST2, 32'h10, "vdd at lower");
    wr(LSF_IDX_SWRST, 8'h01);
    rd(ST2, 32'h00, "soft reset status2");
    chk_irq(1'b0);
  endtask

  // ===========================================================
  // clock, reset and main sequence
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  initial begin
    presetn = 1'b0;
    fault = 1'b0;
    vld = '0;
    for (int k = 0; k < LSF_NCH; k++) begin
      res[k] = 8'h80;
    end
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_int();
    t_ext();
    t_fault_ain();
    t_vdd();
    summarize();
  end
endmodule
`default_nettype wire

// *** verilog/lsf_limit_status_flags.sv ***
// Purpose: sticky out-of-limit flags with read-clear, soft reset and interrupt
// Assumes: each result arrives with a one-cycle valid pulse, standard APB master
// Notes: APB answers with zero wait states, read data is captured in setup
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - internal temp above upper limit sets D0
// - internal temp at or below lower sets D1
// - external mode: external above upper sets D2
// - analog mode: input one outside window sets D2
// - external temp at or below lower sets D3
// - external sensor fault sets D4
// - analog two to four outside window set D5-D7
// - supply outside window sets second register D4
// - read clears only flags whose condition ended
// - software reset clears both status registers
// - supply flag is zero after reset
// - supply flag can drive the interrupt output
// - first status register readable at offset zero
// - select field chooses external or analog one
module lsf_limit_status_flags
  import lsf_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [LSF_AW-1:0] paddr,
  input wire logic [LSF_DW-1:0] pwdata,
  output logic pready,
  output logic [LSF_DW-1:0] prdata,
  output logic pslverr,
  input wire logic [LSF_RW-1:0] int_temp_result,
  input wire logic int_temp_valid,
  input wire logic [LSF_RW-1:0] ext_result,
  input wire logic ext_valid,
  input wire logic [LSF_RW-1:0] analog_input_two,
  input wire logic analog_two_valid,
  input wire logic [LSF_RW-1:0] analog_input_three,
  input wire logic analog_three_valid,
  input wire logic [LSF_RW-1:0] analog_input_four,
  input wire logic analog_four_valid,
  input wire logic [LSF_RW-1:0] vdd_result,
  input wire logic vdd_valid,
  input wire logic sensor_fault,
  output logic irq
);

  // ===========================================================
  // declarations
  logic [LSF_RW-1:0] res [LSF_NCH];
  logic [LSF_RW-1:0] hi_r [LSF_NCH];
  logic [LSF_RW-1:0] lo_r [LSF_NCH];
  logic [LSF_NCH-1:0] vld;
  logic [LSF_NCH-1:0] sgn;
  logic [LSF_NCH-1:0] above;
  logic [LSF_NCH-1:0] below;
  logic [LSF_NCH-1:0] hi_hit;
  logic [LSF_NCH-1:0] lo_hit;
  logic [7:0] idx;
  logic aligned;
  logic mapped;
  logic [LSF_RW-1:0] rd_val;
  logic setup_ph;
  logic access_ph;
  logic wr_en;
  logic rd_stat1;
  logic rd_stat2;
  logic soft_rst;
  logic ext_mode;
  logic [LSF_RW-1:0] cfg1_r;
  logic [LSF_RW-1:0] mask1_r;
  logic [LSF_RW-1:0] mask2_r;
  logic [LSF_RW-1:0] cond1_r;
  logic [LSF_RW-1:0] cond1_nxt;
  logic [LSF_RW-1:0] cond2_r;
  logic [LSF_RW-1:0] cond2_nxt;
  logic [LSF_RW-1:0] temp_input_limit_status_r;
  logic [LSF_RW-1:0] temp_input_limit_status_nxt;
  logic [LSF_RW-1:0] supply_limit_status_r;
  logic [LSF_RW-1:0] supply_limit_status_nxt;
  logic [LSF_RW-1:0] f1;
  logic [LSF_RW-1:0] v1;
  logic [LSF_RW-1:0] f2;
  logic [LSF_RW-1:0] v2;
  logic [LSF_RW-1:0] clr1;
  logic [LSF_RW-1:0] clr2;
  logic [LSF_DW-1:0] prdata_r;

  // ===========================================================
  // channel gathering and comparison
  assign res[LSF_CH_INT] = int_temp_result;
  assign res[LSF_CH_EXT] = ext_result;
  assign res[LSF_CH_ANALOG2] = analog_input_two;
  assign res[LSF_CH_ANALOG3] = analog_input_three;
  assign res[LSF_CH_ANALOG4] = analog_input_four;
  assign res[LSF_CH_VDD] = vdd_result;
  assign vld = {vdd_valid, analog_four_valid, analog_three_valid, analog_two_valid,
                ext_valid, int_temp_valid};
  // the shared channel is a twos complement temperature only in external mode
  assign ext_mode = cfg1_r[LSF_CFG_SEL_MSB:LSF_CFG_SEL_LSB] == LSF_SEL_EXT;
  assign sgn = {4'h0, ext_mode, 1'b1};

  genvar gch;
  generate
    for (gch = 0; gch < LSF_NCH; gch++) begin : g_ch
      lsf_window_cmp u_cmp (
        .value(res[gch]),
        .upper(hi_r[gch]),
        .lower(lo_r[gch]),
        .is_signed(sgn[gch]),
        .above(above[gch]),
        .below(below[gch])
      );

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          hi_r[gch] <= LSF_HI_RST[gch];
          lo_r[gch] <= LSF_LO_RST[gch];
        end else if (wr_en) begin
          if (hi_hit[gch]) begin
            hi_r[gch] <= pwdata[LSF_RW-1:0];
          end
          if (lo_hit[gch]) begin
            lo_r[gch] <= pwdata[LSF_RW-1:0];
          end
        end
      end
    end
  endgenerate

  // ===========================================================
  // address decode
  assign idx = paddr[LSF_AW-1:2];
  assign aligned = paddr[1:0] == 2'h0;

  always_comb begin
    mapped = 1'b0;
    rd_val = LSF_REG_RST;
    hi_hit = '0;
    lo_hit = '0;
    if (!aligned) begin
      mapped = 1'b0;
    end else if (idx == LSF_IDX_STAT1) begin
      mapped = 1'b1;
      rd_val = temp_input_limit_status_r;
    end else if (idx == LSF_IDX_STAT2) begin
      mapped = 1'b1;
      rd_val = supply_limit_status_r;
    end else if (idx == LSF_IDX_CFG1) begin
      mapped = 1'b1;
      rd_val = cfg1_r;
    end else if (idx == LSF_IDX_MASK1) begin
      mapped = 1'b1;
      rd_val = mask1_r;
    end else if (idx == LSF_IDX_MASK2) begin
      mapped = 1'b1;
      rd_val = mask2_r;
    end else if (idx == LSF_IDX_SWRST) begin
      mapped = 1'b1;
    end else begin
      for (int ch = 0; ch < LSF_NCH; ch++) begin
        if (idx == LSF_HI_IDX[ch]) begin
          mapped = 1'b1;
          hi_hit[ch] = 1'b1;
          rd_val = hi_r[ch];
        end else if (idx == LSF_LO_IDX[ch]) begin
          mapped = 1'b1;
          lo_hit[ch] = 1'b1;
          rd_val = lo_r[ch];
        end
      end
    end
  end

  // ===========================================================
  // APB slave
  assign setup_ph = psel && !penable;
  assign access_ph = psel && penable;
  assign wr_en = access_ph && pwrite && mapped;
  assign rd_stat1 = access_ph && !pwrite && aligned && idx == LSF_IDX_STAT1;
  assign rd_stat2 = access_ph && !pwrite && aligned && idx == LSF_IDX_STAT2;
  assign soft_rst = wr_en && idx == LSF_IDX_SWRST && pwdata[LSF_SWRST_BIT];
  assign pready = 1'b1;
  assign pslverr = access_ph && !mapped;
  assign prdata = prdata_r;

  // read data is frozen in setup so the clear below knows what software saw
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= '0;
    end else if (setup_ph && !pwrite) begin
      prdata_r <= mapped ? {24'h000000, rd_val} : '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg1_r <= LSF_REG_RST;
      mask1_r <= LSF_REG_RST;
      mask2_r <= LSF_REG_RST;
    end else if (wr_en) begin
      if (idx == LSF_IDX_CFG1) begin
        cfg1_r <= pwdata[LSF_RW-1:0];
      end
      if (idx == LSF_IDX_MASK1) begin
        mask1_r <= pwdata[LSF_RW-1:0];
      end
      if (idx == LSF_IDX_MASK2) begin
        mask2_r <= pwdata[LSF_RW-1:0];
      end
    end
  end

  // ===========================================================
  // out-of-limit conditions and events
  always_comb begin
    f1 = '0;
    v1 = '0;
    f2 = '0;
    v2 = '0;
    f1[LSF_ST1_INT_HI] = above[LSF_CH_INT];
    f1[LSF_ST1_INT_LO] = below[LSF_CH_INT];
    v1[LSF_ST1_INT_HI] = vld[LSF_CH_INT];
    v1[LSF_ST1_INT_LO] = vld[LSF_CH_INT];
    if (ext_mode) begin
      f1[LSF_ST1_EXT_HI] = above[LSF_CH_EXT];
    end else begin
      f1[LSF_ST1_EXT_HI] = above[LSF_CH_EXT] || below[LSF_CH_EXT];
    end
    f1[LSF_ST1_EXT_LO] = ext_mode && below[LSF_CH_EXT];
    v1[LSF_ST1_EXT_HI] = vld[LSF_CH_EXT];
    v1[LSF_ST1_EXT_LO] = vld[LSF_CH_EXT];
    // fault is a live level, so it is both condition and event every cycle
    f1[LSF_ST1_FAULT] = sensor_fault;
    v1[LSF_ST1_FAULT] = 1'b1;
    f1[LSF_ST1_ANALOG2] = above[LSF_CH_ANALOG2] || below[LSF_CH_ANALOG2];
    f1[LSF_ST1_ANALOG3] = above[LSF_CH_ANALOG3] || below[LSF_CH_ANALOG3];
    f1[LSF_ST1_ANALOG4] = above[LSF_CH_ANALOG4] || below[LSF_CH_ANALOG4];
    v1[LSF_ST1_ANALOG2] = vld[LSF_CH_ANALOG2];
    v1[LSF_ST1_ANALOG3] = vld[LSF_CH_ANALOG3];
    v1[LSF_ST1_ANALOG4] = vld[LSF_CH_ANALOG4];
    f2[LSF_ST2_VDD] = above[LSF_CH_VDD] || below[LSF_CH_VDD];
    v2[LSF_ST2_VDD] = vld[LSF_CH_VDD];
  end

  assign cond1_nxt = (v1 & f1) | (~v1 & cond1_r);
  assign cond2_nxt = ((v2 & f2) | (~v2 & cond2_r)) & LSF_ST2_USED;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cond1_r <= LSF_REG_RST;
      cond2_r <= LSF_REG_RST;
    end else if (soft_rst) begin
      cond1_r <= LSF_REG_RST;
      cond2_r <= LSF_REG_RST;
    end else begin
      cond1_r <= cond1_nxt;
      cond2_r <= cond2_nxt;
    end
  end

  // ===========================================================
  // sticky status, read clear, software reset
  // only bits that were reported and whose condition has gone may clear
  assign clr1 = rd_stat1 ? (prdata_r[LSF_RW-1:0] & ~cond1_r) : '0;
  assign clr2 = rd_stat2 ? (prdata_r[LSF_RW-1:0] & ~cond2_r) : '0;
  // a new event wins over a read clear in the same cycle
  assign temp_input_limit_status_nxt = (temp_input_limit_status_r & ~clr1) | (v1 & f1);
  assign supply_limit_status_nxt = ((supply_limit_status_r & ~clr2) | (v2 & f2)) & LSF_ST2_USED;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      temp_input_limit_status_r <= LSF_REG_RST;
      supply_limit_status_r <= LSF_REG_RST;
    end else if (soft_rst) begin
      temp_input_limit_status_r <= LSF_REG_RST;
      supply_limit_status_r <= LSF_REG_RST;
    end else begin
      temp_input_limit_status_r <= temp_input_limit_status_nxt;
      supply_limit_status_r <= supply_limit_status_nxt;
    end
  end

  // ===========================================================
  // interrupt: a set mask bit blocks its flag
  assign irq = |(temp_input_limit_status_r & ~mask1_r) ||
               |(supply_limit_status_r & ~mask2_r);

  // ===========================================================
  // assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  int_hi_flag_a: assert property (
    int_temp_valid && !soft_rst && $signed(int_temp_result) > $signed(hi_r[LSF_CH_INT])
    |=> temp_input_limit_status_r[LSF_ST1_INT_HI]) else $error("internal upper flag missed");
  int_lo_flag_a: assert property (
    int_temp_valid && !soft_rst && $signed(int_temp_result) <= $signed(lo_r[LSF_CH_INT])
    |=> temp_input_limit_status_r[LSF_ST1_INT_LO]) else $error("internal lower flag missed");
  ext_hi_flag_a: assert property (
    ext_mode && ext_valid && !soft_rst && $signed(ext_result) > $signed(hi_r[LSF_CH_EXT])
    |=> temp_input_limit_status_r[LSF_ST1_EXT_HI]) else $error("external upper flag missed");
  analog_one_win_a: assert property (
    !ext_mode && ext_valid && !soft_rst &&
    (ext_result > hi_r[LSF_CH_EXT] || ext_result <= lo_r[LSF_CH_EXT])
    |=> temp_input_limit_status_r[LSF_ST1_EXT_HI]) else $error("analog one flag missed");
  ext_lo_flag_a: assert property (
    ext_mode && ext_valid && !soft_rst && $signed(ext_result) <= $signed(lo_r[LSF_CH_EXT])
    |=> temp_input_limit_status_r[LSF_ST1_EXT_LO]) else $error("external lower flag missed");
  fault_flag_a: assert property (sensor_fault && !soft_rst
    |=> temp_input_limit_status_r[LSF_ST1_FAULT]) else $error("fault flag missed");
  analog_four_win_a: assert property (
    analog_four_valid && !soft_rst &&
    (analog_input_four > hi_r[LSF_CH_ANALOG4] || analog_input_four <= lo_r[LSF_CH_ANALOG4])
    |=> temp_input_limit_status_r[LSF_ST1_ANALOG4]) else $error("analog four flag missed");
  vdd_flag_a: assert property (
    vdd_valid && !soft_rst &&
    (vdd_result > hi_r[LSF_CH_VDD] || vdd_result <= lo_r[LSF_CH_VDD])
    |=> supply_limit_status_r[LSF_ST2_VDD]) else $error("supply flag missed");
  stat2_unused_a: assert property (
    (supply_limit_status_r & ~LSF_ST2_USED) == 8'h00)
    else $error("unused supply status bit set");
  rd_keep_a: assert property (rd_stat1 && !soft_rst
    |=> (temp_input_limit_status_r & $past(temp_input_limit_status_r & cond1_r))
        == $past(temp_input_limit_status_r & cond1_r)) else $error("active flag cleared by read");
  soft_clear_a: assert property (soft_rst
    |=> temp_input_limit_status_r == 8'h00 && supply_limit_status_r == 8'h00)
    else $error("soft reset left a flag");
  vdd_irq_a: assert property (
    supply_limit_status_r[LSF_ST2_VDD] && !mask2_r[LSF_ST2_VDD]
    |-> irq) else $error("supply flag did not raise interrupt");
  stat1_read_a: assert property (
    setup_ph && !pwrite && aligned && idx == LSF_IDX_STAT1
    |=> prdata[LSF_RW-1:0] == $past(temp_input_limit_status_r))
    else $error("status read wrong");
  flag_hold_a: assert property (!rd_stat1 && !soft_rst
    |=> (temp_input_limit_status_r & $past(temp_input_limit_status_r))
        == $past(temp_input_limit_status_r)) else $error("flag dropped without clear");
  irq_idle_a: assert property (
    temp_input_limit_status_r == 8'h00 && supply_limit_status_r == 8'h00
    |-> !irq) else $error("interrupt without flag");
  irq_mask_a: assert property (
    (temp_input_limit_status_r & ~mask1_r) == 8'h00 &&
    (supply_limit_status_r & ~mask2_r) == 8'h00
    |-> !irq) else $error("masked flag raised interrupt");

  ext_event_c: cover property (ext_mode && ext_valid && above[LSF_CH_EXT]);
  read_clear_c: cover property (rd_stat1 && clr1 != 8'h00);
  irq_rise_c: cover property (!irq ##1 irq);
  soft_reset_c: cover property (soft_rst && temp_input_limit_status_r != 8'h00);

endmodule
`default_nettype wire

// *** verilog/lsf_pkg.sv ***
// Purpose: shared constants for the out-of-limit status flag block
// Assumes: register indices are word indices, byte address is four times the index
// Notes: limit defaults are 8-bit codes, temperatures in twos complement
package lsf_pkg;

  // ===========================================================
  // channel layout
  localparam int LSF_NCH = 6;
  localparam int LSF_CH_INT = 0;
  localparam int LSF_CH_EXT = 1;
  localparam int LSF_CH_ANALOG2 = 2;
  localparam int LSF_CH_ANALOG3 = 3;
  localparam int LSF_CH_ANALOG4 = 4;
  localparam int LSF_CH_VDD = 5;

  // ===========================================================
  // bus and register indices
  localparam int LSF_AW = 10;
  localparam int LSF_DW = 32;
  localparam int LSF_RW = 8;
  localparam logic [7:0] LSF_IDX_STAT1 = 8'h00;
  localparam logic [7:0] LSF_IDX_STAT2 = 8'h01;
  localparam logic [7:0] LSF_IDX_CFG1 = 8'h18;
  localparam logic [7:0] LSF_IDX_MASK1 = 8'h1D;
  localparam logic [7:0] LSF_IDX_MASK2 = 8'h1E;
  localparam logic [7:0] LSF_IDX_SWRST = 8'h31;
  localparam logic [7:0] LSF_HI_IDX [LSF_NCH] = '{8'h25, 8'h27, 8'h2B, 8'h2D, 8'h2F, 8'h23};
  localparam logic [7:0] LSF_LO_IDX [LSF_NCH] = '{8'h26, 8'h28, 8'h2C, 8'h2E, 8'h30, 8'h24};

  // ===========================================================
  // reset values
  localparam logic [7:0] LSF_HI_RST [LSF_NCH] = '{8'h64, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hC7};
  localparam logic [7:0] LSF_LO_RST [LSF_NCH] = '{8'hC9, 8'h00, 8'h00, 8'h00, 8'h00, 8'h62};
  localparam logic [7:0] LSF_REG_RST = 8'h00;

  // ===========================================================
  // field positions
  localparam int LSF_ST1_INT_HI = 0;
  localparam int LSF_ST1_INT_LO = 1;
  localparam int LSF_ST1_EXT_HI = 2;
  localparam int LSF_ST1_EXT_LO = 3;
  localparam int LSF_ST1_FAULT = 4;
  localparam int LSF_ST1_ANALOG2 = 5;
  localparam int LSF_ST1_ANALOG3 = 6;
  localparam int LSF_ST1_ANALOG4 = 7;
  localparam int LSF_ST2_VDD = 4;
  localparam logic [7:0] LSF_ST2_USED = 8'h10;
  localparam int LSF_CFG_SEL_LSB = 1;
  localparam int LSF_CFG_SEL_MSB = 2;
  localparam logic [1:0] LSF_SEL_EXT = 2'h1;
  localparam int LSF_SWRST_BIT = 0;

endpackage

// *** verilog/lsf_window_cmp.sv ***
// Purpose: upper/lower limit comparison for one channel
// Assumes: value and limits share one 8-bit code
// Notes: above is strictly greater, below includes equality
`timescale 1ns/10ps
`default_nettype none
module lsf_window_cmp
  import lsf_pkg::*;
(
  input wire logic [LSF_RW-1:0] value,
  input wire logic [LSF_RW-1:0] upper,
  input wire logic [LSF_RW-1:0] lower,
  input wire logic is_signed,
  output logic above,
  output logic below
);

  // ===========================================================
  // compare
  always_comb begin
    if (is_signed) begin
      above = $signed(value) > $signed(upper);
      below = $signed(value) <= $signed(lower);
    end else begin
      above = value > upper;
      below = value <= lower;
    end
  end

endmodule
`default_nettype wire
